// ==== verilog/ufis_defs.svh ====
// constants and rule overview for the uart flow, infrared and sleep block
// Overview of operation
// - compare one or two characters per mode
// - pause match stops transmitter after current character
// - pause match sets flag and interrupt, both only if enabled
// - resume match restarts transmitter, clears status flag
// - four character registers reset to zero
// - double mode needs two consecutive matches
// - matched flow characters not stored in FIFO
// - fill crossing trigger sends pause after two characters
// - fill at or under lower step sends resume characters
// - special detect compares second pause, stores, flags
// - compare only word length bits, lsb aligned
// - infrared encoder emits 3/16 pulse per zero
// - infrared enable idles output and input low
// - decoder maps pulse to one, optional inversion
// - sleep only when all seven conditions hold
// - sleeping stops oscillator output toggling
// - wake on start edge, byte write, modem change
// - resleep after service, never with interrupt pending
// - character registers reachable only with 0xBF control
`ifndef UFIS_DEFS_SVH
`define UFIS_DEFS_SVH
`define UFIS_CHAR_RESET     8'h00
`define UFIS_BANK_KEY       8'hBF
`define UFIS_IER_PAUSE_BIT  5
`define UFIS_IER_SLEEP_BIT  4
`define UFIS_MCR_INV_BIT    2
`define UFIS_MCR_IR_BIT     6
`define UFIS_EFR_SPECIAL_BIT 5
`define UFIS_ISR_FLOW_BIT   4
`define UFIS_IR_PULSE_NUM   3
`define UFIS_IR_PULSE_DEN   16
`define UFIS_PAUSE_DELAY_CHARS 2
`endif

// ==== verilog/ufis_pkg.sv ====
// types shared by the uart flow, infrared and sleep block
package ufis_pkg;
  typedef enum logic [1:0] {
    UFIS_FLOW_OFF    = 2'b00,
    UFIS_FLOW_SINGLE = 2'b01,
    UFIS_FLOW_DOUBLE = 2'b10
  } ufis_flow_mode_t;
  typedef enum logic [1:0] {
    UFIS_TX_IDLE  = 2'b00,
    UFIS_TX_FIRST = 2'b01,
    UFIS_TX_SECOND = 2'b10
  } ufis_tx_state_t;
  typedef struct packed {
    logic [3:0] phase;
    logic       pulse;
    logic [2:0] s_rx;
  } ufis_ir_t;
endpackage

// ==== verilog/ufis_ir_codec.sv ====
// infrared pulse encoder and decoder
`timescale 1ns/1ps
`include "ufis_defs.svh"
module ufis_ir_codec (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic baud16_en,
  input  wire logic ir_enable,
  input  wire logic rx_invert,
  input  wire logic tx_bit,
  input  wire logic tx_bit_start,
  input  wire logic rx_pin,
  output logic      ir_tx_out,
  output logic      ir_rx_bit
);
  ufis_pkg::ufis_ir_t st_reg;
  ufis_pkg::ufis_ir_t st_next;
  logic rx_meta_reg;
  always_comb begin
    st_next = st_reg;
    st_next.s_rx = {st_reg.s_rx[1:0], rx_meta_reg};
    if (tx_bit_start) begin
      st_next.phase = 4'h0;
      st_next.pulse = ir_enable & ~tx_bit;
    end else if (baud16_en) begin
      st_next.phase = st_reg.phase + 4'h1;
      if (st_reg.phase == 4'(`UFIS_IR_PULSE_NUM - 1)) begin
        st_next.pulse = 1'b0;
      end
    end
    if (!ir_enable) begin
      st_next.pulse = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg      <= '0;
      rx_meta_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      rx_meta_reg <= rx_pin;
    end
  end
  assign ir_tx_out = st_reg.pulse;
  // light pulse is a one unless inverted; idle low reads as zero
  assign ir_rx_bit = st_reg.s_rx[1] ^ rx_invert;
endmodule

// ==== verilog/ufis_core.sv ====
// flow control, special detect, infrared and sleep logic of one channel
`timescale 1ns/1ps
`include "ufis_defs.svh"
module ufis_core #(
  parameter int CLK_HZ    = 100000000,
  parameter int OSC_DIV   = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        baud16_en,
  input  wire logic [7:0]  line_control_reg,
  input  wire logic [7:0]  interrupt_enable_reg,
  input  wire logic [7:0]  modem_control_reg,
  input  wire logic [7:0]  enhanced_feature_reg,
  input  wire logic [1:0]  flow_mode,
  input  wire logic        char_wr,
  input  wire logic [1:0]  char_sel,
  input  wire logic [7:0]  char_wdata,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic [4:0]  rx_fill,
  input  wire logic [1:0]  rx_trig_sel,
  input  wire logic        tx_char_done,
  input  wire logic        tx_bit,
  input  wire logic        tx_bit_start,
  input  wire logic        thr_write,
  input  wire logic        other_int_pending,
  input  wire logic        other_sleep_en,
  input  wire logic        other_rx_idle,
  input  wire logic        msr_read,
  input  wire logic [3:0]  modem_in,
  input  wire logic        rx_pin,
  input  wire logic        serial_tx,
  output logic             rx_store,
  output logic [7:0]       rx_store_data,
  output logic             tx_halt,
  output logic             flow_tx_req,
  output logic [7:0]       flow_tx_char,
  output logic             flow_status,
  output logic             irq,
  output logic [7:0]       char_rdata,
  output logic [3:0]       modem_delta,
  output logic             sleeping,
  output logic             osc_enable,
  output logic             oscillator_output_pin,
  output logic             tx_pin,
  output logic             rx_line
);
  // pause wait of two characters, ten bits each, sixteen ticks a bit
  localparam int PAUSE_TICKS = `UFIS_PAUSE_DELAY_CHARS * 10 * 16;
  typedef struct packed {
    logic [7:0]  resume1;
    logic [7:0]  resume2;
    logic [7:0]  pause1;
    logic [7:0]  pause2;
    logic        half_resume;
    logic        half_pause;
    logic        halt_pend;
    logic        halt;
    logic        pause_flag;
    logic        spec_flag;
    logic        sent_pause;
    logic        delay_run;
    logic [9:0]  delay_cnt;
    ufis_pkg::ufis_tx_state_t tx_st;
    logic        tx_pause;
    logic        store;
    logic [7:0]  store_data;
    logic [3:0]  mod_s1;
    logic [3:0]  mod_s2;
    logic [3:0]  mod_old;
    logic [3:0]  delta;
    logic [1:0]  rx_s;
    logic        rx_old;
    logic        sleep;
    logic [7:0]  osc_cnt;
    logic        osc_out;
    logic        tx_out;
    logic        rx_out;
    logic [7:0]  rdata;
    logic        irq_out;
    logic        req_out;
    logic [7:0]  char_out;
    logic        osc_en;
  } st_t;
  st_t s_reg;
  st_t s_next;
  logic ir_tx;
  logic ir_rx;
  logic [7:0] wmask;
  logic [4:0] xoff_lvl;
  logic [4:0] xon_lvl;
  logic m_p1;
  logic m_p2;
  logic m_r1;
  logic m_r2;
  logic pause_hit;
  logic resume_hit;
  logic double_mode;
  logic flow_on;
  logic bank_open;
  logic int_pend;
  logic sleep_ok;
  logic wake;
  ufis_ir_codec u_ir (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .baud16_en    (baud16_en),
    .ir_enable    (modem_control_reg[`UFIS_MCR_IR_BIT]),
    .rx_invert    (modem_control_reg[`UFIS_MCR_INV_BIT]),
    .tx_bit       (tx_bit),
    .tx_bit_start (tx_bit_start),
    .rx_pin       (rx_pin),
    .ir_tx_out    (ir_tx),
    .ir_rx_bit    (ir_rx)
  );
  always_comb begin
    unique case (line_control_reg[1:0])
      2'b00: wmask = 8'h1F;
      2'b01: wmask = 8'h3F;
      2'b10: wmask = 8'h7F;
      2'b11: wmask = 8'hFF;
    endcase
    unique case (rx_trig_sel)
      2'b00: begin
        xoff_lvl = 5'h01;
        xon_lvl  = 5'h00;
      end
      2'b01: begin
        xoff_lvl = 5'h04;
        xon_lvl  = 5'h01;
      end
      2'b10: begin
        xoff_lvl = 5'h08;
        xon_lvl  = 5'h04;
      end
      2'b11: begin
        xoff_lvl = 5'h0E;
        xon_lvl  = 5'h08;
      end
    endcase
  end
  assign m_p1 = ((rx_char ^ s_reg.pause1) & wmask) == 8'h00;
  assign m_p2 = ((rx_char ^ s_reg.pause2) & wmask) == 8'h00;
  assign m_r1 = ((rx_char ^ s_reg.resume1) & wmask) == 8'h00;
  assign m_r2 = ((rx_char ^ s_reg.resume2) & wmask) == 8'h00;
  assign flow_on = flow_mode != ufis_pkg::UFIS_FLOW_OFF;
  assign double_mode = flow_mode == ufis_pkg::UFIS_FLOW_DOUBLE;
  assign pause_hit = flow_on & rx_char_valid &
                     (double_mode ? (s_reg.half_pause & m_p2) : m_p1);
  assign resume_hit = flow_on & rx_char_valid & s_reg.halt &
                      (double_mode ? (s_reg.half_resume & m_r2) : m_r1);
  assign bank_open = line_control_reg == `UFIS_BANK_KEY;
  assign int_pend = s_reg.pause_flag | s_reg.spec_flag |
                    (s_reg.delta != 4'h0);
  assign sleep_ok = !int_pend && !other_int_pending &&
                    interrupt_enable_reg[`UFIS_IER_SLEEP_BIT] &&
                    other_sleep_en && s_reg.delta == 4'h0 &&
                    s_reg.rx_s[1] && other_rx_idle;
  always_comb begin
    s_next = s_reg;
    s_next.store = 1'b0;
    s_next.mod_s1 = modem_in;
    s_next.mod_s2 = s_reg.mod_s1;
    s_next.mod_old = s_reg.mod_s2;
    s_next.rx_s = {s_reg.rx_s[0], rx_pin};
    s_next.rx_old = s_reg.rx_s[1];
    if (char_wr && bank_open) begin
      unique case (char_sel)
        2'b00: s_next.resume1 = char_wdata;
        2'b01: s_next.resume2 = char_wdata;
        2'b10: s_next.pause1 = char_wdata;
        2'b11: s_next.pause2 = char_wdata;
      endcase
    end
    unique case (char_sel)
      2'b00: s_next.rdata = bank_open ? s_reg.resume1 : 8'h00;
      2'b01: s_next.rdata = bank_open ? s_reg.resume2 : 8'h00;
      2'b10: s_next.rdata = bank_open ? s_reg.pause1 : 8'h00;
      2'b11: s_next.rdata = bank_open ? s_reg.pause2 : 8'h00;
    endcase
    // host read clears, a detect in the same cycle wins
    if (msr_read) begin
      s_next.spec_flag = 1'b0;
    end
    if (rx_char_valid) begin
      s_next.half_pause = double_mode & m_p1;
      s_next.half_resume = double_mode & m_r1;
      if (!(flow_on && (m_p1 || m_p2 || m_r1 || m_r2) &&
            (!double_mode || s_reg.half_pause || s_reg.half_resume ||
             m_p1 || m_r1))) begin
        s_next.store = 1'b1;
        s_next.store_data = rx_char;
      end
      if (enhanced_feature_reg[`UFIS_EFR_SPECIAL_BIT] && m_p2) begin
        s_next.store = 1'b1;
        s_next.store_data = rx_char;
        s_next.spec_flag = 1'b1;
      end
    end
    if (pause_hit) begin
      s_next.halt_pend = 1'b1;
      s_next.pause_flag =
        interrupt_enable_reg[`UFIS_IER_PAUSE_BIT];
    end
    if (s_reg.halt_pend && tx_char_done) begin
      s_next.halt_pend = 1'b0;
      s_next.halt = 1'b1;
    end
    if (resume_hit) begin
      s_next.halt = 1'b0;
      s_next.halt_pend = 1'b0;
      s_next.pause_flag = 1'b0;
      s_next.spec_flag = 1'b0;
    end
    if (flow_on && !s_reg.sent_pause && rx_fill >= xoff_lvl &&
        !s_reg.delay_run) begin
      s_next.delay_run = 1'b1;
      s_next.delay_cnt = 10'(PAUSE_TICKS - 1);
    end else if (s_reg.delay_run && baud16_en) begin
      if (s_reg.delay_cnt == 10'h000) begin
        s_next.delay_run = 1'b0;
        s_next.sent_pause = 1'b1;
        s_next.tx_pause = 1'b1;
        s_next.tx_st = ufis_pkg::UFIS_TX_FIRST;
      end else begin
        s_next.delay_cnt = s_reg.delay_cnt - 10'h001;
      end
    end
    if (s_reg.sent_pause && s_reg.tx_st == ufis_pkg::UFIS_TX_IDLE &&
        rx_fill <= xon_lvl && (xon_lvl != 5'h00 || rx_fill == 5'h00) &&
        rx_fill < xoff_lvl) begin
      s_next.sent_pause = 1'b0;
      s_next.tx_pause = 1'b0;
      s_next.tx_st = ufis_pkg::UFIS_TX_FIRST;
    end
    if (tx_char_done) begin
      unique case (s_reg.tx_st)
        ufis_pkg::UFIS_TX_IDLE: s_next.tx_st = ufis_pkg::UFIS_TX_IDLE;
        ufis_pkg::UFIS_TX_FIRST: s_next.tx_st = double_mode ?
          ufis_pkg::UFIS_TX_SECOND : ufis_pkg::UFIS_TX_IDLE;
        ufis_pkg::UFIS_TX_SECOND: s_next.tx_st = ufis_pkg::UFIS_TX_IDLE;
        default: s_next.tx_st = ufis_pkg::UFIS_TX_IDLE;
      endcase
    end
    // modem change detect, cleared by host read, change wins
    if (msr_read) begin
      s_next.delta = 4'h0;
    end
    if (s_reg.mod_s2 != s_reg.mod_old) begin
      s_next.delta = s_next.delta | (s_reg.mod_s2 ^ s_reg.mod_old);
    end
    if (sleep_ok) begin
      s_next.sleep = 1'b1;
    end
    if (wake || int_pend || other_int_pending ||
        !interrupt_enable_reg[`UFIS_IER_SLEEP_BIT]) begin
      s_next.sleep = 1'b0;
    end
    if (!s_reg.sleep) begin
      if (s_reg.osc_cnt == 8'(OSC_DIV - 1)) begin
        s_next.osc_cnt = 8'h00;
        s_next.osc_out = ~s_reg.osc_out;
      end else begin
        s_next.osc_cnt = s_reg.osc_cnt + 8'h01;
      end
    end else begin
      s_next.osc_out = 1'b0;
    end
    if (modem_control_reg[`UFIS_MCR_IR_BIT]) begin
      s_next.tx_out = ir_tx;
      s_next.rx_out = ir_rx;
    end else begin
      s_next.tx_out = serial_tx;
      s_next.rx_out = s_reg.rx_s[1];
    end
    // outputs registered from the next state, no extra cycle of lag
    s_next.irq_out = s_next.pause_flag | s_next.spec_flag;
    s_next.req_out = s_next.tx_st != ufis_pkg::UFIS_TX_IDLE;
    s_next.char_out = (s_next.tx_st == ufis_pkg::UFIS_TX_SECOND) ?
      (s_next.tx_pause ? s_next.pause2 : s_next.resume2) :
      (s_next.tx_pause ? s_next.pause1 : s_next.resume1);
    s_next.osc_en = ~s_next.sleep;
  end
  assign wake = (s_reg.rx_old & ~s_reg.rx_s[1]) | thr_write |
                (s_reg.mod_s2 != s_reg.mod_old);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.resume1 <= `UFIS_CHAR_RESET;
      s_reg.resume2 <= `UFIS_CHAR_RESET;
      s_reg.pause1 <= `UFIS_CHAR_RESET;
      s_reg.pause2 <= `UFIS_CHAR_RESET;
      s_reg.rx_s <= 2'b11;
      s_reg.rx_old <= 1'b1;
      s_reg.tx_out <= 1'b1;
      s_reg.rx_out <= 1'b1;
      s_reg.osc_en <= 1'b1;
      s_reg.tx_st <= ufis_pkg::UFIS_TX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end
  assign rx_store = s_reg.store;
  assign rx_store_data = s_reg.store_data;
  assign tx_halt = s_reg.halt;
  assign flow_tx_req = s_reg.req_out;
  assign flow_tx_char = s_reg.char_out;
  assign flow_status = s_reg.irq_out;
  assign irq = s_reg.irq_out;
  assign char_rdata = s_reg.rdata;
  assign modem_delta = s_reg.delta;
  assign sleeping = s_reg.sleep;
  assign osc_enable = s_reg.osc_en;
  assign oscillator_output_pin = s_reg.osc_out;
  assign tx_pin = s_reg.tx_out;
  assign rx_line = s_reg.rx_out;
endmodule

// ==== sim/ufis_core_asserts.sv ====
// assertion checker for the flow, infrared and sleep block
`timescale 1ns/1ps
module ufis_core_asserts (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic [7:0] line_control_reg,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [1:0] flow_mode,
  input wire logic       char_wr,
  input wire logic [1:0] char_sel,
  input wire logic [7:0] char_wdata,
  input wire logic       rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic       thr_write,
  input wire logic       other_int_pending,
  input wire logic       other_sleep_en,
  input wire logic       other_rx_idle,
  input wire logic       rx_store,
  input wire logic       tx_halt,
  input wire logic       irq,
  input wire logic [7:0] char_rdata,
  input wire logic [3:0] modem_delta,
  input wire logic       sleeping,
  input wire logic       oscillator_output_pin
);
  logic [7:0] shadow_reg [4];
  logic [7:0] wmask;
  logic       key;
  assign key = line_control_reg == 8'hBF;
  assign wmask = 8'hFF >> (2'h3 - line_control_reg[1:0]);
  // copy of the four character registers, written only with the key
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shadow_reg <= '{default: 8'h00};
    end else if (char_wr && key) begin
      shadow_reg[char_sel] <= char_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence pause_hit;
    rx_char_valid && flow_mode == 2'h1 &&
      ((rx_char ^ shadow_reg[2]) & wmask) == 8'h00;
  endsequence
  sequence held_awake;
    (other_int_pending || !interrupt_enable_reg[4]) [*2];
  endsequence
  plain_store_a: assert property (
    rx_char_valid && flow_mode == 2'h0 |=> rx_store)
    else $error("plain character not stored");
  flow_drop_a: assert property (pause_hit |=> !rx_store)
    else $error("pause character stored");
  pause_irq_a: assert property (
    pause_hit ##0 interrupt_enable_reg[5] &&
      shadow_reg[2] != shadow_reg[0] |=> irq)
    else $error("pause match without interrupt");
  resume_only_a: assert property (
    $fell(tx_halt) |-> $past(rx_char_valid) || $past(rx_char_valid, 2))
    else $error("halt released without a character");
  locked_read_a: assert property (!key |=> char_rdata == 8'h00)
    else $error("character register readable without key");
  char_read_a: assert property (
    key && !char_wr |=> char_rdata == shadow_reg[$past(char_sel)])
    else $error("character register read back wrong");
  sleep_entry_a: assert property (
    $rose(sleeping) |-> $past(interrupt_enable_reg[4] && other_sleep_en &&
      other_rx_idle && !other_int_pending && !irq && modem_delta == 4'h0))
    else $error("sleep entered with a condition open");
  held_awake_a: assert property (held_awake |-> !sleeping)
    else $error("asleep while pending or disabled");
  osc_stop_a: assert property (
    sleeping [*8] |-> $stable(oscillator_output_pin))
    else $error("oscillator runs in sleep");
  wake_write_a: assert property (
    sleeping && thr_write |-> ##[1:3] !sleeping)
    else $error("no wake on transmit write");
endmodule
bind ufis_core ufis_core_asserts u_chk (.sys_clk, .resetn,
  .line_control_reg, .interrupt_enable_reg, .flow_mode, .char_wr,
  .char_sel, .char_wdata, .rx_char_valid, .rx_char, .thr_write,
  .other_int_pending, .other_sleep_en, .other_rx_idle, .rx_store,
  .tx_halt, .irq, .char_rdata, .modem_delta, .sleeping,
  .oscillator_output_pin);

// ==== sim/ufis_remote.sv ====
// remote transceiver model: received characters and the rx line
`timescale 1ns/1ps
module ufis_remote (
  input  wire logic       sys_clk,
  output logic            rx_char_valid,
  output logic [7:0]      rx_char,
  output logic            rx_pin
);
  initial begin
    rx_char_valid = 1'b0;
    rx_char       = 8'hFF;
    rx_pin        = 1'b1;
  end
  // valid for one cycle, then the bus shows the inverse
  task automatic send(input logic [7:0] c);
    rx_char_valid = 1'b1;
    rx_char       = c;
    @(posedge sys_clk);
    #1;
    rx_char_valid = 1'b0;
    rx_char       = ~c;
  endtask
  // start bit of sixteen clocks; the model drives the line back high to idle
  task automatic start_bit;
    rx_pin = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    rx_pin = 1'b1;
  endtask
endmodule

// ==== sim/tb_ufis_core.sv ====
// self-checking bench for the flow, infrared and sleep block
`timescale 1ns/1ps
module tb_ufis_core;
  logic       sys_clk = 1'b0, resetn = 1'b0, baud16_en = 1'b0;
  logic [7:0] line_control_reg = 8'h03, interrupt_enable_reg = 8'h00;
  logic [7:0] modem_control_reg = 8'h00, enhanced_feature_reg = 8'h00;
  logic [1:0] flow_mode = 2'h0, char_sel = 2'h0, rx_trig_sel = 2'h0;
  logic       char_wr = 1'b0, tx_char_done = 1'b0, tx_bit = 1'b1;
  logic       tx_bit_start = 1'b0, thr_write = 1'b0, msr_read = 1'b0;
  logic       other_int_pending = 1'b0, other_sleep_en = 1'b1;
  logic       other_rx_idle = 1'b1, serial_tx = 1'b1;
  logic [7:0] char_wdata = 8'h00, rx_char, rx_store_data;
  logic [7:0] flow_tx_char, char_rdata;
  logic [4:0] rx_fill = 5'h00;
  logic [3:0] modem_in = 4'h0, modem_delta;
  logic       rx_char_valid, rx_pin, rx_store, tx_halt, flow_tx_req;
  logic       flow_status, irq, sleeping, osc_enable;
  logic       oscillator_output_pin, tx_pin, rx_line;
  int         mismatches = 0;
  int         check_count = 0;
  ufis_core #(.OSC_DIV(4)) DUT (.*);
  ufis_remote rem (.*);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) baud16_en <= ~baud16_en;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic cb(input logic got, exp, input string m);
    chk({7'h00, got}, {7'h00, exp}, m);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    char_sel = s;
    char_wdata = d;
    pulse(char_wr);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    char_sel = s;
    cyc(1);
    chk(char_rdata, e, "char read");
  endtask
  task automatic zz(input logic lvl, input int n, input string m);
    for (int i = 0; i < n && sleeping !== lvl; i++) cyc(1);
    cb(sleeping, lvl, m);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_regs;
    line_control_reg = 8'hBF;
    for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
    line_control_reg = 8'h03;
    wr(2'h2, 8'h5A);
    rd(2'h2, 8'h00);
    line_control_reg = 8'hBF;
    rd(2'h2, 8'h00);
    wr(2'h0, 8'h11);
    wr(2'h1, 8'h91);
    wr(2'h2, 8'h13);
    wr(2'h3, 8'h93);
    rd(2'h3, 8'h93);
    line_control_reg = 8'h03;
    $display("test regs done");
  endtask
  task automatic t_pause;
    flow_mode = 2'h1;
    interrupt_enable_reg = 8'h20;
    rem.send(8'h41);
    chk(rx_store_data, 8'h41, "plain data");
    cyc(1);
    rem.send(8'h13);
    cb(rx_store, 1'b0, "pause stored");
    cb(irq, 1'b1, "pause irq");
    serial_tx = 1'b0;
    cyc(2);
    cb(tx_halt, 1'b0, "halt waits for char end");
    serial_tx = 1'b1;
    pulse(tx_char_done);
    cb(tx_halt, 1'b1, "halt after char");
    rem.send(8'h11);
    cyc(2);
    cb(tx_halt, 1'b0, "resume");
    cb(irq, 1'b0, "flag cleared");
    $display("test pause done");
  endtask
  task automatic t_double;
    flow_mode = 2'h2;
    rem.send(8'h13);
    cyc(1);
    rem.send(8'h55);
    pulse(tx_char_done);
    cb(tx_halt, 1'b0, "half pair");
    rem.send(8'h13);
    cyc(1);
    rem.send(8'h93);
    cb(rx_store, 1'b0, "pair stored");
    pulse(tx_char_done);
    cb(tx_halt, 1'b1, "pair halt");
    rem.send(8'h11);
    cyc(1);
    rem.send(8'h91);
    cyc(2);
    cb(tx_halt, 1'b0, "pair resume");
    flow_mode = 2'h0;
    $display("test double done");
  endtask
  task automatic t_special;
    enhanced_feature_reg = 8'h20;
    line_control_reg = 8'h00;
    rem.send(8'hF3);
    cb(rx_store, 1'b1, "special stored");
    cyc(1);
    cb(flow_status, 1'b1, "special flag");
    pulse(msr_read);
    enhanced_feature_reg = 8'h00;
    line_control_reg = 8'h03;
    $display("test special done");
  endtask
  task automatic t_auto;
    int n;
    n = 0;
    flow_mode = 2'h1;
    rx_trig_sel = 2'h1;
    rx_fill = 5'd4;
    for (n = 0; n < 900 && flow_tx_req !== 1'b1; n++) cyc(1);
    chk(flow_tx_char, 8'h13, "pause sent");
    cb(n >= 600, 1'b1, "pause delay");
    pulse(tx_char_done);
    rx_fill = 5'd1;
    for (n = 0; n < 900 && flow_tx_char !== 8'h11; n++) cyc(1);
    cb(flow_tx_req, 1'b1, "resume sent");
    pulse(tx_char_done);
    rx_fill = 5'd0;
    flow_mode = 2'h0;
    $display("test auto done");
  endtask
  task automatic t_ir;
    int n;
    n = 0;
    modem_control_reg = 8'h40;
    cyc(8);
    cb(tx_pin, 1'b0, "ir idle");
    cb(rx_line, 1'b1, "ir pulse is one");
    modem_control_reg = 8'h44;
    cyc(2);
    cb(rx_line, 1'b0, "ir inverted");
    modem_control_reg = 8'h40;
    tx_bit = 1'b0;
    pulse(tx_bit_start);
    for (int i = 0; i < 40; i++) begin
      n += tx_pin;
      cyc(1);
    end
    cb(n >= 5 && n <= 7, 1'b1, "ir pulse");
    tx_bit = 1'b1;
    modem_control_reg = 8'h00;
    cyc(40);
    cb(tx_pin, 1'b1, "plain idle");
    cb(rx_line, 1'b1, "plain rx idle");
    $display("test ir done");
  endtask
  task automatic t_sleep;
    logic o;
    interrupt_enable_reg = 8'h10;
    zz(1'b1, 60, "sleep entry");
    cyc(1);
    o = oscillator_output_pin;
    cyc(20);
    cb(oscillator_output_pin, o, "osc stopped");
    cb(osc_enable, 1'b0, "osc disabled");
    thr_write = 1'b1;
    cyc(1);
    thr_write = 1'b0;
    cb(sleeping, 1'b0, "write wake");
    zz(1'b1, 60, "resleep");
    modem_in = 4'h1;
    zz(1'b0, 10, "modem wake");
    cyc(30);
    cb(sleeping, 1'b0, "awaits status read");
    chk({4'h0, modem_delta}, 8'h01, "modem change");
    pulse(msr_read);
    zz(1'b1, 60, "resleep after read");
    rem.start_bit();
    cb(sleeping, 1'b0, "start bit wake");
    zz(1'b1, 60, "resleep after frame");
    other_int_pending = 1'b1;
    zz(1'b0, 3, "pending wakes");
    other_sleep_en = 1'b0;
    other_int_pending = 1'b0;
    cyc(20);
    cb(sleeping, 1'b0, "other channel disabled");
    other_sleep_en = 1'b1;
    other_rx_idle = 1'b0;
    cyc(20);
    cb(sleeping, 1'b0, "other rx busy");
    other_rx_idle = 1'b1;
    zz(1'b1, 60, "pending served");
    interrupt_enable_reg = 8'h00;
    cyc(50);
    cb(sleeping, 1'b0, "sleep disabled");
    $display("test sleep done");
  endtask
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
  initial begin
    cyc(10);
    resetn = 1'b1;
    cyc(1);
    t_regs();
    t_pause();
    t_double();
    t_special();
    t_auto();
    t_ir();
    t_sleep();
    close_out();
  end
endmodule
